// File: hw/pssc_top.sv
// Pin-strap configuration of a four-to-one link switch with AHB-Lite access.
// Assumes static strap pins synchronous to CLK and a single AHB-Lite master.
// Operation
// (RULE_01) Select 00..11 routes sources A..D
// (RULE_02) Auxiliary switch always on in parallel
// (RULE_03) Select routes auxiliary port to A..D
// (RULE_04) Input termination forced on in parallel
// (RULE_05) Termination pulse on switch forced off
// (RULE_06) One equalization setting for all inputs
// (RULE_07) Equalization pin: 0 low 6dB, 1 high 12dB
// (RULE_08) Pre-emphasis pins: 0, 2, 4, 6 dB
// (RULE_09) Output termination follows its pin
// (RULE_10) Drive current 10 mA or 20 mA
// (RULE_11) Board should strap high equalization
// (RULE_12) Enable pin 0 gives standby, 1 on
// (RULE_13) Pins govern until first register access
// (RULE_14) Settings track live pin levels continuously while in parallel mode
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pssc_defines.svh"
module pssc_top #(
  parameter int SEL_W = 2
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [SEL_W-1:0] SOURCE_SELECT_PINS,
  input wire logic EQ_LEVEL_PIN,
  input wire logic [1:0] PREEMPH_LEVEL_PINS,
  input wire logic OUT_TERM_PIN,
  input wire logic OUT_CURRENT_PIN,
  input wire logic HS_CHANNEL_ENABLE_PIN,
  output logic PARALLEL_MODE,
  output logic HS_ENABLE,
  output logic STANDBY,
  output logic [(1<<SEL_W)-1:0] HS_ROUTE,
  output logic AUX_ENABLE,
  output logic [(1<<SEL_W)-1:0] AUX_COMMON_PORT_ROUTE,
  output logic [(1<<SEL_W)-1:0] IN_TERM_EN,
  output logic [(1<<SEL_W)-1:0] IN_TERM_PULSE_EN,
  output logic [(1<<SEL_W)-1:0] EQ_HIGH,
  output logic [4*(1<<SEL_W)-1:0] EQ_DB,
  output logic [1:0] PREEMPH_LEVEL,
  output logic [2:0] PREEMPH_DB,
  output logic OUT_TERM_EN,
  output logic TX_CURRENT_LEVEL,
  output logic [4:0] TX_CURRENT_MA
);

  localparam int SRC_N = 1 << SEL_W;

  pssc_pkg::pssc_mode_e mode, next_mode;
  logic reg_hs_en, next_reg_hs_en;
  pssc_pkg::pssc_sel_t reg_hs_sel, next_reg_hs_sel;
  logic reg_aux_en, next_reg_aux_en;
  pssc_pkg::pssc_sel_t reg_aux_sel, next_reg_aux_sel;
  logic [SRC_N-1:0] reg_in_term, next_reg_in_term;
  logic [SRC_N-1:0] reg_pulse, next_reg_pulse;
  logic [SRC_N-1:0] reg_eq, next_reg_eq;
  logic [1:0] reg_pe, next_reg_pe;
  logic reg_oto, next_reg_oto;
  logic reg_ocl, next_reg_ocl;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  pssc_pkg::pssc_word_t rdata, next_rdata;
  logic access;
  logic [7:0] pin_word;

  // Effective settings feeding the output stage
  logic eff_hs_en, eff_aux_en, eff_oto, eff_ocl;
  logic [SEL_W-1:0] eff_hs_sel, eff_aux_sel;
  logic [SRC_N-1:0] eff_in_term, eff_pulse, eff_eq;
  logic [1:0] eff_pe;
  logic [SRC_N-1:0] hs_hot, aux_hot;

  // Zero-wait slave; every transfer answers OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata;
  assign access = HSEL && HTRANS[1] && HREADY;
  assign pin_word = {1'b0, HS_CHANNEL_ENABLE_PIN, OUT_CURRENT_PIN, OUT_TERM_PIN,
                     PREEMPH_LEVEL_PINS, EQ_LEVEL_PIN, SOURCE_SELECT_PINS[0]};

  // Mode, software copies and bus phase
  always_comb
  begin
    next_mode = mode;
    next_reg_hs_en = reg_hs_en;
    next_reg_hs_sel = reg_hs_sel;
    next_reg_aux_en = reg_aux_en;
    next_reg_aux_sel = reg_aux_sel;
    next_reg_in_term = reg_in_term;
    next_reg_pulse = reg_pulse;
    next_reg_eq = reg_eq;
    next_reg_pe = reg_pe;
    next_reg_oto = reg_oto;
    next_reg_ocl = reg_ocl;
    next_wr_pend = access && HWRITE;
    next_wr_addr = HADDR[7:0];
    next_rdata = '0;
    // First access hands control to software, seeded from the live straps and the forced parallel values
    if (mode == pssc_pkg::PSSC_PARALLEL && access) // RULE_13
    begin
      next_mode = pssc_pkg::PSSC_SERIAL;
      next_reg_hs_en = HS_CHANNEL_ENABLE_PIN;
      next_reg_hs_sel = SOURCE_SELECT_PINS;
      next_reg_aux_en = 1'b1;
      next_reg_aux_sel = SOURCE_SELECT_PINS;
      next_reg_in_term = '1;
      next_reg_pulse = '0;
      next_reg_eq = {SRC_N{EQ_LEVEL_PIN}};
      next_reg_pe = PREEMPH_LEVEL_PINS;
      next_reg_oto = OUT_TERM_PIN;
      next_reg_ocl = OUT_CURRENT_PIN;
    end
    // Write data phase; unmapped offsets are ignored
    if (wr_pend)
    begin
      case (wr_addr)
        `PSSC_OFF_HS_CTRL:
        begin
          next_reg_hs_en = HWDATA[`PSSC_POS_ENABLE];
          next_reg_hs_sel = HWDATA[1:0];
        end
        `PSSC_OFF_AUX_CTRL:
        begin
          next_reg_aux_en = HWDATA[`PSSC_POS_ENABLE];
          next_reg_aux_sel = HWDATA[1:0];
        end
        `PSSC_OFF_RX_TERM: next_reg_in_term = HWDATA[SRC_N-1:0];
        `PSSC_OFF_RX_PULSE: next_reg_pulse = HWDATA[SRC_N-1:0];
        `PSSC_OFF_RX_EQ: next_reg_eq = HWDATA[SRC_N-1:0];
        `PSSC_OFF_TX:
        begin
          next_reg_pe = HWDATA[`PSSC_POS_PE+1:`PSSC_POS_PE];
          next_reg_oto = HWDATA[`PSSC_POS_OTO];
          next_reg_ocl = HWDATA[`PSSC_POS_OCL];
        end
        default: next_reg_hs_en = next_reg_hs_en;
      endcase
    end
    // Read from post-write values so a back-to-back read sees the write
    if (access && !HWRITE && HADDR[31:8] == 24'h000000)
    begin
      case (HADDR[7:0])
        `PSSC_OFF_STATUS:
        begin
          next_rdata[0] = (next_mode == pssc_pkg::PSSC_PARALLEL);
          next_rdata[`PSSC_POS_PINS+7:`PSSC_POS_PINS] = pin_word;
          next_rdata[`PSSC_POS_PINS+SEL_W-1:`PSSC_POS_PINS] = SOURCE_SELECT_PINS;
        end
        `PSSC_OFF_HS_CTRL:
        begin
          next_rdata[`PSSC_POS_ENABLE] = next_reg_hs_en;
          next_rdata[1:0] = next_reg_hs_sel;
        end
        `PSSC_OFF_AUX_CTRL:
        begin
          next_rdata[`PSSC_POS_ENABLE] = next_reg_aux_en;
          next_rdata[1:0] = next_reg_aux_sel;
        end
        `PSSC_OFF_RX_TERM: next_rdata[SRC_N-1:0] = next_reg_in_term;
        `PSSC_OFF_RX_PULSE: next_rdata[SRC_N-1:0] = next_reg_pulse;
        `PSSC_OFF_RX_EQ: next_rdata[SRC_N-1:0] = next_reg_eq;
        `PSSC_OFF_TX:
        begin
          next_rdata[`PSSC_POS_PE+1:`PSSC_POS_PE] = next_reg_pe;
          next_rdata[`PSSC_POS_OTO] = next_reg_oto;
          next_rdata[`PSSC_POS_OCL] = next_reg_ocl;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      mode <= pssc_pkg::PSSC_PARALLEL;
      reg_hs_en <= `PSSC_RST_HS_EN;
      reg_hs_sel <= `PSSC_RST_SEL;
      reg_aux_en <= `PSSC_RST_AUX_EN;
      reg_aux_sel <= `PSSC_RST_SEL;
      reg_in_term <= `PSSC_RST_IN_TERM;
      reg_pulse <= `PSSC_RST_PULSE;
      reg_eq <= `PSSC_RST_EQ;
      reg_pe <= `PSSC_RST_PE;
      reg_oto <= `PSSC_RST_OTO;
      reg_ocl <= `PSSC_RST_OCL;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= '0;
    end
    else
    begin
      mode <= next_mode;
      reg_hs_en <= next_reg_hs_en;
      reg_hs_sel <= next_reg_hs_sel;
      reg_aux_en <= next_reg_aux_en;
      reg_aux_sel <= next_reg_aux_sel;
      reg_in_term <= next_reg_in_term;
      reg_pulse <= next_reg_pulse;
      reg_eq <= next_reg_eq;
      reg_pe <= next_reg_pe;
      reg_oto <= next_reg_oto;
      reg_ocl <= next_reg_ocl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      rdata <= next_rdata;
    end
  end

  // Source of each setting: live straps or forced values in parallel mode, else software copies
  always_comb
  begin
    if (mode == pssc_pkg::PSSC_PARALLEL) // RULE_14
    begin
      eff_hs_en = HS_CHANNEL_ENABLE_PIN; // RULE_12
      eff_hs_sel = SOURCE_SELECT_PINS; // RULE_01
      eff_aux_en = 1'b1; // RULE_02
      eff_aux_sel = SOURCE_SELECT_PINS; // RULE_03
      eff_in_term = '1; // RULE_04
      eff_pulse = '0; // RULE_05
      eff_eq = {SRC_N{EQ_LEVEL_PIN}}; // RULE_06
      eff_pe = PREEMPH_LEVEL_PINS; // RULE_08
      eff_oto = OUT_TERM_PIN; // RULE_09
      eff_ocl = OUT_CURRENT_PIN; // RULE_10
    end
    else
    begin
      eff_hs_en = reg_hs_en;
      eff_hs_sel = reg_hs_sel;
      eff_aux_en = reg_aux_en;
      eff_aux_sel = reg_aux_sel;
      eff_in_term = reg_in_term;
      eff_pulse = reg_pulse;
      eff_eq = reg_eq;
      eff_pe = reg_pe;
      eff_oto = reg_oto;
      eff_ocl = reg_ocl;
    end
  end

  // Standby leaves every high-speed path dark
  pssc_onehot #(.SEL_W(SEL_W)) u_hs_route (
    .sel(eff_hs_sel),
    .en(eff_hs_en),
    .hot(hs_hot)
  );

  pssc_onehot #(.SEL_W(SEL_W)) u_aux_route (
    .sel(eff_aux_sel),
    .en(eff_aux_en),
    .hot(aux_hot)
  );

  // Registered outputs, one cycle behind the pins, keep glitches off the analog side
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      PARALLEL_MODE <= 1'b1;
      HS_ENABLE <= 1'b0;
      STANDBY <= 1'b1;
      HS_ROUTE <= '0;
      AUX_ENABLE <= 1'b1;
      AUX_COMMON_PORT_ROUTE <= '0;
      IN_TERM_EN <= '1;
      IN_TERM_PULSE_EN <= '0;
      EQ_HIGH <= '0;
      EQ_DB <= '0;
      PREEMPH_LEVEL <= 2'h0;
      PREEMPH_DB <= 3'h0;
      OUT_TERM_EN <= 1'b0;
      TX_CURRENT_LEVEL <= 1'b0;
      TX_CURRENT_MA <= `PSSC_CUR_LOW_MA;
    end
    else
    begin
      PARALLEL_MODE <= (mode == pssc_pkg::PSSC_PARALLEL);
      HS_ENABLE <= eff_hs_en;
      STANDBY <= !eff_hs_en; // RULE_12
      HS_ROUTE <= hs_hot; // RULE_01
      AUX_ENABLE <= eff_aux_en;
      AUX_COMMON_PORT_ROUTE <= aux_hot; // RULE_03
      IN_TERM_EN <= eff_in_term;
      IN_TERM_PULSE_EN <= eff_pulse;
      EQ_HIGH <= eff_eq;
      for (int i = 0; i < SRC_N; i++)
      begin
        EQ_DB[4*i +: 4] <= eff_eq[i] ? `PSSC_EQ_HIGH_DB : `PSSC_EQ_LOW_DB; // RULE_07
      end
      PREEMPH_LEVEL <= eff_pe;
      PREEMPH_DB <= {eff_pe, 1'b0}; // RULE_08
      OUT_TERM_EN <= eff_oto;
      TX_CURRENT_LEVEL <= eff_ocl;
      TX_CURRENT_MA <= eff_ocl ? `PSSC_CUR_HIGH_MA : `PSSC_CUR_LOW_MA; // RULE_10
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Outputs still hold reset values on the first edge after release, hence $past(NRST)
  hs_route_sel_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_01
    && $past(HS_CHANNEL_ENABLE_PIN) |-> HS_ROUTE == SRC_N'(1 << $past(SOURCE_SELECT_PINS)))
    else $error("High-speed route does not follow select pins");
  aux_always_on_a: assert property (PARALLEL_MODE |-> AUX_ENABLE) // RULE_02
    else $error("Auxiliary switch off in parallel mode");
  aux_route_sel_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_03
    |-> AUX_COMMON_PORT_ROUTE == SRC_N'(1 << $past(SOURCE_SELECT_PINS)))
    else $error("Auxiliary route does not follow select pins");
  in_term_on_a: assert property (PARALLEL_MODE |-> IN_TERM_EN == '1) // RULE_04
    else $error("Input termination not forced on");
  pulse_off_a: assert property (PARALLEL_MODE |-> IN_TERM_PULSE_EN == '0) // RULE_05
    else $error("Termination pulse not forced off");
  eq_global_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_06
    |-> EQ_HIGH == {SRC_N{$past(EQ_LEVEL_PIN)}})
    else $error("Equalization not shared by all inputs");
  eq_db_a: assert property ($past(NRST) |-> EQ_DB[3:0] == // RULE_07
    (EQ_HIGH[0] ? `PSSC_EQ_HIGH_DB : `PSSC_EQ_LOW_DB))
    else $error("Equalization level decode wrong");
  preemph_pins_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_08
    |-> PREEMPH_LEVEL == $past(PREEMPH_LEVEL_PINS)
    && PREEMPH_DB == {$past(PREEMPH_LEVEL_PINS), 1'b0})
    else $error("Pre-emphasis decode wrong");
  out_term_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_09
    |-> OUT_TERM_EN == $past(OUT_TERM_PIN))
    else $error("Output termination does not follow its pin");
  drive_current_a: assert property ($past(NRST) && PARALLEL_MODE // RULE_10
    |-> TX_CURRENT_MA == ($past(OUT_CURRENT_PIN) ? `PSSC_CUR_HIGH_MA : `PSSC_CUR_LOW_MA))
    else $error("Drive current decode wrong");
  standby_dark_a: assert property (STANDBY |-> !HS_ENABLE && HS_ROUTE == '0) // RULE_12
    else $error("High-speed path live in standby");
  mode_handover_a: assert property (mode == pssc_pkg::PSSC_PARALLEL && access // RULE_13
    |=> mode == pssc_pkg::PSSC_SERIAL ##1 !PARALLEL_MODE [*3])
    else $error("Pins still govern after first access");
  // Keyed on the live mode: an access hands over to software at the next edge, a cycle before PARALLEL_MODE drops
  pins_tracked_a: assert property (mode == pssc_pkg::PSSC_PARALLEL // RULE_14
    && $changed(HS_CHANNEL_ENABLE_PIN) |=> HS_ENABLE == $past(HS_CHANNEL_ENABLE_PIN))
    else $error("Strap change not followed");

  first_access_c: cover property (mode == pssc_pkg::PSSC_PARALLEL && access);
  serial_write_c: cover property (mode == pssc_pkg::PSSC_SERIAL && wr_pend);
  sel_change_c: cover property (PARALLEL_MODE && $changed(HS_ROUTE) && HS_ENABLE);
  standby_c: cover property (PARALLEL_MODE && STANDBY);

endmodule : pssc_top
`default_nettype wire

// File: hw/pssc_defines.svh
// Register offsets, field positions, reset values and decode figures of the
// pin-strap switch configuration block.
// Assumes inclusion by bare name from the design files.
`ifndef PSSC_DEFINES_SVH
`define PSSC_DEFINES_SVH

// Byte offsets on the register bus
`define PSSC_OFF_STATUS 8'h00
`define PSSC_OFF_HS_CTRL 8'h04
`define PSSC_OFF_AUX_CTRL 8'h08
`define PSSC_OFF_RX_TERM 8'h0c
`define PSSC_OFF_RX_PULSE 8'h10
`define PSSC_OFF_RX_EQ 8'h14
`define PSSC_OFF_TX 8'h18

// Field positions
`define PSSC_POS_ENABLE 6
`define PSSC_POS_PE 2
`define PSSC_POS_OTO 1
`define PSSC_POS_OCL 0
`define PSSC_POS_PINS 8

// Reset values of the software copies
`define PSSC_RST_HS_EN 1'b0
`define PSSC_RST_SEL 2'h0
`define PSSC_RST_AUX_EN 1'b1
`define PSSC_RST_IN_TERM 4'hf
`define PSSC_RST_PULSE 4'h0
`define PSSC_RST_EQ 4'hf
`define PSSC_RST_PE 2'h0
`define PSSC_RST_OTO 1'b0
`define PSSC_RST_OCL 1'b0

// Decoded levels
`define PSSC_EQ_LOW_DB 4'h6
`define PSSC_EQ_HIGH_DB 4'hc
`define PSSC_CUR_LOW_MA 5'h0a
`define PSSC_CUR_HIGH_MA 5'h14

`endif

// File: hw/pssc_pkg.sv
// Types shared by the pin-strap switch configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package pssc_pkg;

  // Who governs the settings
  typedef enum logic {PSSC_PARALLEL, PSSC_SERIAL} pssc_mode_e;

  typedef logic [1:0] pssc_sel_t;
  typedef logic [31:0] pssc_word_t;

endpackage : pssc_pkg

// File: hw/pssc_onehot.sv
// One-hot source decoder with an enable.
// Assumes a binary select held static by its driver.
`timescale 1ns/1ps
`default_nettype none
module pssc_onehot #(
  parameter int SEL_W = 2
) (
  input wire logic [SEL_W-1:0] sel,
  input wire logic en,
  output logic [(1<<SEL_W)-1:0] hot
);

  // All paths dark when disabled, so no source leaks through
  always_comb
  begin
    hot = '0;
    if (en)
    begin
      hot[sel] = 1'b1;
    end
  end

endmodule : pssc_onehot
`default_nettype wire

// File: verif/pssc_strap_model.sv
// Board strap model: static pin levels for the switch configuration block.
// Assumes the bench hands it a packed strap word; pins move just after an edge.
`timescale 1ns/1ps
`default_nettype none
module pssc_strap_model (
  input wire logic clk,
  input wire logic [7:0] strap_word,
  output logic [1:0] source_select_pins,
  output logic eq_level_pin,
  output logic [1:0] preemph_level_pins,
  output logic out_term_pin,
  output logic out_current_pin,
  output logic hs_channel_enable_pin
);
  // Unknown until the first edge; the bench holds reset over that time
  logic [7:0] held;
  // Straps are resoldered between edges only, never on one
  always_ff @(posedge clk)
  begin
    held <= strap_word;
  end
  // Word layout: en, current, out term, pre-emphasis, eq, select
  assign {hs_channel_enable_pin, out_current_pin, out_term_pin} = held[7:5];
  assign preemph_level_pins = held[4:3];
  assign eq_level_pin = held[2];
  assign source_select_pins = held[1:0];
endmodule : pssc_strap_model
`default_nettype wire

// File: verif/test_pin_strap_switch_config.sv
// Self-checking bench for the pin-strap switch configuration block.
// Assumes one AHB-Lite slave with zero wait states and the strap model above.
`timescale 1ns/1ps
`default_nettype none
module test_pin_strap_switch_config;
  logic clk, nrst, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hreadyout, hresp, par, hs_en, stby, aux_en, oto_en, cur_lvl;
  logic [1:0] sel_p, pe_p, pe_lvl;
  logic eq_p, oto_p, ocl_p, en_p;
  logic [3:0] hs_route, aux_route, term_en, pulse_en, eq_hi;
  logic [15:0] eq_db;
  logic [2:0] pe_db;
  logic [4:0] cur_ma;
  logic [7:0] strap, c;
  int bad_count = 0;
  int checks_done = 0;

  // Clock at 200 MHz
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  pssc_strap_model straps_u (.clk(clk), .strap_word(strap), .source_select_pins(sel_p),
    .eq_level_pin(eq_p), .preemph_level_pins(pe_p), .out_term_pin(oto_p),
    .out_current_pin(ocl_p), .hs_channel_enable_pin(en_p));

  pssc_top dut_u (.CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SOURCE_SELECT_PINS(sel_p), .EQ_LEVEL_PIN(eq_p),
    .PREEMPH_LEVEL_PINS(pe_p), .OUT_TERM_PIN(oto_p), .OUT_CURRENT_PIN(ocl_p),
    .HS_CHANNEL_ENABLE_PIN(en_p), .PARALLEL_MODE(par), .HS_ENABLE(hs_en), .STANDBY(stby),
    .HS_ROUTE(hs_route), .AUX_ENABLE(aux_en), .AUX_COMMON_PORT_ROUTE(aux_route),
    .IN_TERM_EN(term_en), .IN_TERM_PULSE_EN(pulse_en), .EQ_HIGH(eq_hi), .EQ_DB(eq_db),
    .PREEMPH_LEVEL(pe_lvl), .PREEMPH_DB(pe_db), .OUT_TERM_EN(oto_en),
    .TX_CURRENT_LEVEL(cur_lvl), .TX_CURRENT_MA(cur_ma));

  task automatic close_out();
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One AHB-Lite single transfer; held until hready is seen high
  task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, 1'b0);
  endtask : ahb_xfer

  // Pins move one edge after the word, outputs one edge after the pins
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // Every decoded setting against the strap word w
  task automatic check_all(input logic [7:0] w);
    chk("hs_route", hs_route, w[7] ? (4'h1 << w[1:0]) : 4'h0);
    chk("hs_enable", {stby, hs_en}, w[7] ? 2'h1 : 2'h2);
    chk("aux_route", {aux_en, aux_route}, {1'b1, 4'h1 << w[1:0]});
    chk("term", {term_en, pulse_en}, 8'hf0);
    chk("eq_high", eq_hi, {4{w[2]}});
    chk("eq_db", eq_db, {4{w[2] ? 4'hc : 4'h6}});
    chk("preemph", {pe_lvl, pe_db}, {w[4:3], w[4:3], 1'b0});
    chk("out_term", oto_en, w[5]);
    chk("current", {cur_lvl, cur_ma}, {w[6], w[6] ? 5'h14 : 5'h0a});
  endtask : check_all

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset

  // Watchdog: the whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    // Power-up straps favour high equalization, the safe choice for any cable
    strap = 8'hc4;
    do_reset();
    // Walk every select, pre-emphasis, eq, termination, current and enable value
    for (int i = 0; i < 8; i++)
    begin
      c = {i != 3, i[0], i[1], i[2:1], i[2], i[1:0]};
      strap <= c;
      settle();
      chk("parallel", par, 1'b1);
      check_all(c);
    end
    // First bus access reports the straps other than the equalization pin and hands control to software
    ahb_xfer(1'b0, 32'h0, 32'h0);
    chk("status_pins", rd[15:8], {1'b0, c[7:3], c[1:0]});
    settle();
    chk("parallel", par, 1'b0);
    strap <= ~c;
    settle();
    check_all(c);
    // Software now governs: route, transmitter, readback, refusals
    ahb_xfer(1'b1, 32'h4, 32'h42);
    ahb_xfer(1'b1, 32'h18, 32'hd);
    ahb_xfer(1'b0, 32'h4, 32'h0);
    chk("hs_ctrl", rd, 32'h42);
    ahb_xfer(1'b0, 32'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb_xfer(1'b1, 32'h0, 32'h1);
    ahb_xfer(1'b0, 32'h0, 32'h0);
    chk("status_ro", rd[0], 1'b0);
    settle();
    chk("sw_route", {hs_en, hs_route}, 5'h14);
    chk("sw_tx", {pe_db, oto_en, cur_ma}, {3'h6, 1'b0, 5'h14});
    // Auxiliary off, receiver termination, pulse and per-input equalization by software
    ahb_xfer(1'b1, 32'h8, 32'h1);
    ahb_xfer(1'b1, 32'hc, 32'h5);
    ahb_xfer(1'b1, 32'h10, 32'ha);
    ahb_xfer(1'b1, 32'h14, 32'h3);
    ahb_xfer(1'b0, 32'h14, 32'h0);
    chk("rx_eq_rd", rd, 32'h3);
    settle();
    chk("sw_aux", {aux_en, aux_route}, 5'h00);
    chk("sw_rx", {term_en, pulse_en, eq_hi}, 12'h5a3);
    chk("sw_eq_db", eq_db, 16'h66cc);
    // A second reset gives the straps back
    do_reset();
    settle();
    chk("parallel", par, 1'b1);
    check_all(~c);
    close_out();
  end
endmodule : test_pin_strap_switch_config
`default_nettype wire
